// >>> logic/hcs_pkg.sv
// Constants, field layouts and carrier types of the HDLC control and status slice.
// Assumes one instance per register page; the page decode happens outside.
package hcs_pkg;

   // ---------------------------------------------------------------
   // Register offsets on the parallel microprocessor port
   // ---------------------------------------------------------------
   localparam logic [4:0] ADDR_FIFO     = 5'h12;
   localparam logic [4:0] ADDR_CTRL1    = 5'h13;
   localparam logic [4:0] ADDR_STATUS   = 5'h14;
   localparam logic [4:0] ADDR_INT_STAT = 5'h17;

   localparam logic [7:0] CTRL1_RESET   = 8'h00;
   localparam logic [7:0] RDATA_NONE    = 8'h00;

   // ---------------------------------------------------------------
   // Status register field positions and byte status codes
   // ---------------------------------------------------------------
   localparam int unsigned STAT_INTGEN  = 7;
   localparam int unsigned STAT_IDLE    = 6;
   localparam int unsigned STAT_BS_HI   = 5;
   localparam int unsigned STAT_BS_LO   = 4;
   localparam logic [1:0]  BS_PACKET    = 2'h0;
   localparam logic [1:0]  BS_FIRST     = 2'h1;
   localparam logic [1:0]  BS_LAST_GOOD = 2'h2;
   localparam logic [1:0]  BS_LAST_BAD  = 2'h3;

   // ---------------------------------------------------------------
   // Idle channel and address recognition constants
   // ---------------------------------------------------------------
   localparam logic [3:0] IDLE_ONES     = 4'hf;
   localparam logic [5:0] ALL_CALL1     = 6'h3f;
   localparam logic [6:0] ALL_CALL2     = 7'h7f;

   typedef struct packed {
      logic       adrec;
      logic       receiver_on;
      logic       transmitter_on;
      logic       last_byte_tag;
      logic       abort_tag;
      logic       fill_sel;
      logic [1:0] reserved_bits;
   } hcs_ctrl1_t;

   typedef struct packed {
      logic       last_byte_tag;
      logic       abort_tag;
      logic [7:0] data;
   } hcs_txent_t;

   typedef struct packed {
      logic [1:0] status;
      logic [7:0] data;
   } hcs_rxhead_t;

   typedef struct packed {
      logic [5:0] mask1;
      logic       bit10;
      logic       en1;
      logic [6:0] mask2;
      logic       en2;
      logic       seven;
   } hcs_addrcfg_t;

   typedef enum logic [2:0] {
      RX_OFF = 3'h1, RX_HUNT = 3'h2, RX_FRAME = 3'h4
   } hcs_rx_state_t;

   typedef enum logic [2:0] {
      TX_OFF = 3'h1, TX_FILL = 3'h2, TX_DATA = 3'h4
   } hcs_tx_state_t;

endpackage

// >>> logic/hcs_slice.sv
// Control and status slice of one HDLC controller: control register one, the status
// register, the shared FIFO port, enable sequencing, idle channel and address checks.
// Assumes bus strobes, line bits and engine handshakes are all on ref_clk.
`timescale 1ns/10ps
module hcs_slice (
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   input  wire logic                  ce,
   input  wire logic                  cpu_req,
   input  wire logic                  cpu_we,
   input  wire logic [4:0]            cpu_addr,
   input  wire logic [7:0]            cpu_wdata,
   output logic      [7:0]            cpu_rdata,
   output logic                       cpu_rvalid,
   input  wire logic [7:0]            int_stat_rdata,
   input  wire logic                  irq_event,
   input  wire logic [3:0]            fifo_levels,
   input  wire hcs_pkg::hcs_rxhead_t  rx_head,
   output logic                       rx_fifo_pop,
   output logic                       tx_fifo_push,
   output hcs_pkg::hcs_txent_t        tx_fifo_entry,
   input  wire hcs_pkg::hcs_addrcfg_t addr_cfg,
   input  wire logic                  rx_addr_stb,
   input  wire logic [7:0]            rx_addr1,
   input  wire logic [7:0]            rx_addr2,
   output logic                       rx_addr_ok,
   output logic                       rx_addr_drop,
   input  wire logic                  rx_bit_stb,
   input  wire logic                  rx_bit,
   input  wire logic                  rx_pkt_busy,
   output logic                       rx_clk_en,
   output logic                       rx_hunt,
   input  wire logic                  tx_fifo_empty,
   input  wire logic                  tx_pkt_busy,
   input  wire logic                  tx_byte_done,
   input  wire logic                  tx_byte_last,
   input  wire logic                  tx_byte_abort,
   output logic                       tx_clk_en,
   output logic                       tx_send_data,
   output logic                       tx_fill_idle,
   output logic                       tx_fill_flags,
   output logic                       tx_fcs_req,
   output logic                       tx_abort_req
);
   import hcs_pkg::*;

   // ---------------------------------------------------------------
   // Register port decode
   // ---------------------------------------------------------------
   logic        wr_ctrl, wr_fifo, rd_fifo, rd_int;
   hcs_ctrl1_t  ctrl_r, ctrl_nxt;
   logic        intgen_r, intgen_nxt;
   logic        idle_chan_r, idle_chan_nxt;
   logic        idle_valid_r, idle_valid_nxt;
   logic [3:0]  ones_r, ones_nxt;
   logic [7:0]  rdata_r, rdata_nxt, status_word;
   logic        rvalid_r, rvalid_nxt;
   hcs_txent_t  txent_r, txent_nxt;
   logic        push_r, push_nxt;

   assign wr_ctrl      = cpu_req & cpu_we & (cpu_addr == ADDR_CTRL1);
   assign wr_fifo      = cpu_req & cpu_we & (cpu_addr == ADDR_FIFO);
   assign rd_fifo      = cpu_req & ~cpu_we & (cpu_addr == ADDR_FIFO);
   assign rd_int       = cpu_req & ~cpu_we & (cpu_addr == ADDR_INT_STAT);
   assign rx_fifo_pop  = rd_fifo & ce;
   assign tx_fifo_push = push_r;
   assign tx_fifo_entry = txent_r;
   assign cpu_rdata    = rdata_r;
   assign cpu_rvalid   = rvalid_r;

   always_comb begin
      status_word = {intgen_r, idle_chan_r, rx_head.status, fifo_levels};
   end

   always_comb begin
      ctrl_nxt  = ctrl_r;
      txent_nxt = txent_r;
      push_nxt  = 1'b0;
      rdata_nxt = rdata_r;
      rvalid_nxt = cpu_req & ~cpu_we;
      if (wr_ctrl) begin
         ctrl_nxt = hcs_ctrl1_t'(cpu_wdata);
      end
      if (wr_fifo) begin
         txent_nxt = '{ctrl_r.last_byte_tag, ctrl_r.abort_tag, cpu_wdata};
         push_nxt  = 1'b1;
         ctrl_nxt.last_byte_tag = 1'b0;
         ctrl_nxt.abort_tag     = 1'b0;
      end
      if (cpu_req & ~cpu_we) begin
         case (cpu_addr)
            ADDR_FIFO:     rdata_nxt = rx_head.data;
            ADDR_CTRL1:    rdata_nxt = ctrl_r;
            ADDR_STATUS:   rdata_nxt = status_word;
            ADDR_INT_STAT: rdata_nxt = int_stat_rdata;
            default:       rdata_nxt = RDATA_NONE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r   <= hcs_ctrl1_t'(CTRL1_RESET);
         txent_r  <= '0;
         push_r   <= 1'b0;
         rdata_r  <= RDATA_NONE;
         rvalid_r <= 1'b0;
      end else if (ce) begin
         ctrl_r   <= ctrl_nxt;
         txent_r  <= txent_nxt;
         push_r   <= push_nxt;
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt flag and idle channel detection
   // ---------------------------------------------------------------
   always_comb begin
      intgen_nxt = intgen_r;
      if (rd_int) begin
         intgen_nxt = 1'b0;
      end
      if (irq_event) begin
         intgen_nxt = 1'b1;
      end
      ones_nxt       = ones_r;
      idle_valid_nxt = idle_valid_r;
      idle_chan_nxt  = idle_chan_r;
      if (rx_bit_stb) begin
         if (rx_bit) begin
            if (ones_r != IDLE_ONES) begin
               ones_nxt = ones_r + 4'h1;
            end
            if (ones_r >= IDLE_ONES - 4'h1) begin
               idle_valid_nxt = 1'b1;
               idle_chan_nxt  = 1'b1;
            end
         end else begin
            ones_nxt       = 4'h0;
            idle_valid_nxt = 1'b1;
            idle_chan_nxt  = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         intgen_r     <= 1'b0;
         ones_r       <= 4'h0;
         idle_valid_r <= 1'b0;
         idle_chan_r  <= 1'b0;
      end else if (ce) begin
         intgen_r     <= intgen_nxt;
         ones_r       <= ones_nxt;
         idle_valid_r <= idle_valid_nxt;
         idle_chan_r  <= idle_chan_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Receiver sequencing and address recognition
   // ---------------------------------------------------------------
   hcs_rx_state_t rx_st_r, rx_st_nxt;
   logic          aok_r, aok_nxt, adrop_r, adrop_nxt;
   logic          single, all_call, m1, m2, accept;

   always_comb begin
      rx_st_nxt = rx_st_r;
      case (rx_st_r)
         RX_OFF:   if (ctrl_r.receiver_on) rx_st_nxt = RX_HUNT;
         RX_HUNT:  if (!ctrl_r.receiver_on) rx_st_nxt = RX_OFF;
                   else if (rx_pkt_busy) rx_st_nxt = RX_FRAME;
         RX_FRAME: if (!rx_pkt_busy) rx_st_nxt = ctrl_r.receiver_on ? RX_HUNT : RX_OFF;
         default:  rx_st_nxt = RX_OFF;
      endcase
   end

   always_comb begin
      single   = rx_addr1[0];
      all_call = addr_cfg.en1 & (rx_addr1[7:2] == ALL_CALL1)
                 & (single | (addr_cfg.en2 & (rx_addr2[7:1] == ALL_CALL2)));
      m1 = ~addr_cfg.en1 | (addr_cfg.seven ? (rx_addr1[7:1] == {addr_cfg.mask1, addr_cfg.bit10})
                                            : (rx_addr1[7:2] == addr_cfg.mask1));
      m2 = single | ~addr_cfg.en2 | (rx_addr2[7:1] == addr_cfg.mask2);
      accept    = ~ctrl_r.adrec | all_call | (m1 & m2);
      aok_nxt   = rx_addr_stb & accept;
      adrop_nxt = rx_addr_stb & ~accept;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_st_r <= RX_OFF;
         aok_r   <= 1'b0;
         adrop_r <= 1'b0;
      end else if (ce) begin
         rx_st_r <= rx_st_nxt;
         aok_r   <= aok_nxt;
         adrop_r <= adrop_nxt;
      end
   end

   assign rx_clk_en    = (rx_st_r != RX_OFF);
   assign rx_hunt      = (rx_st_r == RX_HUNT);
   assign rx_addr_ok   = aok_r;
   assign rx_addr_drop = adrop_r;

   // ---------------------------------------------------------------
   // Transmitter sequencing, fill selection and tag actions
   // ---------------------------------------------------------------
   hcs_tx_state_t tx_st_r, tx_st_nxt;
   logic          fcs_r, fcs_nxt, abt_r, abt_nxt;

   always_comb begin
      tx_st_nxt = tx_st_r;
      case (tx_st_r)
         TX_OFF:  if (ctrl_r.transmitter_on) tx_st_nxt = tx_fifo_empty ? TX_FILL : TX_DATA;
         TX_FILL: if (!ctrl_r.transmitter_on) tx_st_nxt = TX_OFF;
                  else if (!tx_fifo_empty) tx_st_nxt = TX_DATA;
         TX_DATA: if (!tx_pkt_busy) begin
                     if (!ctrl_r.transmitter_on) tx_st_nxt = TX_OFF;
                     else if (tx_fifo_empty) tx_st_nxt = TX_FILL;
                  end
         default: tx_st_nxt = TX_OFF;
      endcase
      fcs_nxt = tx_byte_done & tx_byte_last & ~tx_byte_abort;
      abt_nxt = tx_byte_done & tx_byte_abort;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tx_st_r <= TX_OFF;
         fcs_r   <= 1'b0;
         abt_r   <= 1'b0;
      end else if (ce) begin
         tx_st_r <= tx_st_nxt;
         fcs_r   <= fcs_nxt;
         abt_r   <= abt_nxt;
      end
   end

   assign tx_clk_en     = (tx_st_r != TX_OFF);
   assign tx_send_data  = (tx_st_r == TX_DATA);
   assign tx_fill_idle  = (tx_st_r == TX_FILL) & ~ctrl_r.fill_sel;
   assign tx_fill_flags = (tx_st_r == TX_FILL) & ctrl_r.fill_sel;
   assign tx_fcs_req    = fcs_r;
   assign tx_abort_req  = abt_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_rx_start;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & rx_st_r == RX_OFF & ctrl_r.receiver_on) |=> rx_hunt & rx_clk_en;
   endproperty
   a_rx_start: assert property (p_rx_start) else $error("receiver did not start");

   property p_rx_finish;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & rx_st_r == RX_FRAME & rx_pkt_busy) |=> rx_clk_en;
   endproperty
   a_rx_finish: assert property (p_rx_finish) else $error("receiver stopped mid packet");

   property p_rx_gate;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & rx_st_r != RX_FRAME & !ctrl_r.receiver_on & !$past(ctrl_r.receiver_on))
      |=> !rx_clk_en;
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("receiver clock not gated");

   property p_tx_start;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & tx_st_r == TX_OFF & ctrl_r.transmitter_on)
      |=> tx_clk_en & (tx_send_data == !$past(tx_fifo_empty));
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("transmitter did not start");

   property p_tx_finish;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & tx_send_data & tx_pkt_busy) |=> tx_send_data;
   endproperty
   a_tx_finish: assert property (p_tx_finish) else $error("packet cut short");

   property p_tx_gate;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & !tx_send_data & !ctrl_r.transmitter_on) |=> !tx_clk_en;
   endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("transmitter clock mismatch");

   property p_tag_clear;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & wr_fifo) |=> tx_fifo_push & !ctrl_r.last_byte_tag & !ctrl_r.abort_tag
                         & (tx_fifo_entry.last_byte_tag == $past(ctrl_r.last_byte_tag));
   endproperty
   a_tag_clear: assert property (p_tag_clear) else $error("tag not moved or cleared");

   property p_fcs;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & tx_byte_done & tx_byte_last & !tx_byte_abort) |=> tx_fcs_req & !tx_abort_req;
   endproperty
   a_fcs: assert property (p_fcs) else $error("no frame check after last byte");

   property p_intgen;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & irq_event) |=> intgen_r;
   endproperty
   a_intgen: assert property (p_intgen) else $error("interrupt flag lost");

   property p_idle;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & rx_bit_stb & !rx_bit) |=> idle_valid_r & !idle_chan_r & (ones_r == 4'h0);
   endproperty
   a_idle: assert property (p_idle) else $error("idle channel not cleared by zero");

   property p_drop;
      @(posedge ref_clk) disable iff (!resetn)
      (ce & rx_addr_stb & ctrl_r.adrec & !all_call & !m1) |=> rx_addr_drop & !rx_addr_ok;
   endproperty
   a_drop: assert property (p_drop) else $error("mismatched address accepted");

   c_frame:   cover property (@(posedge ref_clk) rx_st_r == RX_FRAME ##1 rx_st_r == RX_OFF);
   c_fill:    cover property (@(posedge ref_clk) tx_fill_flags ##1 tx_send_data);
   c_idle:    cover property (@(posedge ref_clk) idle_chan_r);
   c_set_clr: cover property (@(posedge ref_clk) ce & irq_event & rd_int);

endmodule // hcs_slice

// >>> tb/hcs_far_model.sv
// Far-side model: a transmit engine that drains tagged bytes, and a receive line bit source.
// Assumes commands arrive on ref_clk rising edges from the bench.
`timescale 1ns/10ps
module hcs_far_model (
   input  wire logic                ref_clk,
   input  wire logic                resetn,
   input  wire logic                tx_fifo_push,
   input  wire hcs_pkg::hcs_txent_t tx_fifo_entry,
   input  wire logic                line_go,
   input  wire logic [4:0]          line_cnt,
   input  wire logic                line_val,
   output logic                     tx_byte_done,
   output logic                     tx_byte_last,
   output logic                     tx_byte_abort,
   output logic                     rx_bit_stb,
   output logic                     rx_bit
);
   import hcs_pkg::*;
   hcs_txent_t ent_r;
   logic [2:0] wait_r;
   logic [4:0] left_r;
   logic       val_r;

   // Tags are only meaningful with the done pulse; otherwise they show the inverse.
   assign tx_byte_last  = tx_byte_done ? ent_r.last_byte_tag : ~ent_r.last_byte_tag;
   assign tx_byte_abort = tx_byte_done ? ent_r.abort_tag : ~ent_r.abort_tag;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ent_r        <= '0;
         wait_r       <= 3'h0;
         left_r       <= 5'h0;
         val_r        <= 1'b0;
         rx_bit       <= 1'b0;
         rx_bit_stb   <= 1'b0;
         tx_byte_done <= 1'b0;
      end else begin
         tx_byte_done <= (wait_r == 3'h1) && !tx_fifo_push;
         if (tx_fifo_push) begin
            ent_r  <= tx_fifo_entry;
            wait_r <= 3'h4;
         end else if (wait_r != 3'h0) begin
            wait_r <= wait_r - 3'h1;
         end
         // Between bursts the line toggles so a stale bit is never mistaken for data.
         rx_bit_stb <= (left_r != 5'h0);
         rx_bit     <= (left_r != 5'h0) ? val_r : ~rx_bit;
         if (line_go) begin
            left_r <= line_cnt;
            val_r  <= line_val;
         end else if (left_r != 5'h0) begin
            left_r <= left_r - 5'h1;
         end
      end
   end
endmodule // hcs_far_model

// >>> tb/hcs_slice_tb.sv
// Self-checking bench for the HDLC control and status slice.
// Assumes the far-side model drains transmit bytes and sources receive line bits.
`timescale 1ns/10ps
module hcs_slice_tb;
   import hcs_pkg::*;
   logic         ref_clk, resetn = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0, ce = 1'b1;
   logic [4:0]   cpu_addr = 5'h0;
   logic [7:0]   cpu_wdata = 8'h0, cpu_rdata, rx_addr1 = 8'h0, rx_addr2 = 8'h0, rd_v;
   logic         cpu_rvalid, irq_event = 1'b0, rx_fifo_pop, tx_fifo_push;
   hcs_rxhead_t  rx_head = '0;
   hcs_txent_t   tx_fifo_entry;
   hcs_addrcfg_t addr_cfg = '0;
   logic         rx_addr_stb = 1'b0, rx_addr_ok, rx_addr_drop, rx_bit_stb, rx_bit;
   logic         rx_pkt_busy = 1'b0, rx_clk_en, rx_hunt;
   logic         tx_fifo_empty = 1'b1, tx_pkt_busy = 1'b0;
   logic         tx_byte_done, tx_byte_last, tx_byte_abort, tx_clk_en, tx_send_data;
   logic         tx_fill_idle, tx_fill_flags, tx_fcs_req, tx_abort_req;
   logic         line_go = 1'b0, line_val = 1'b0;
   logic [4:0]   line_cnt = 5'h0;
   int           err_total = 0;
   int           cmp_count = 0;

   hcs_slice dut_u (.ref_clk, .resetn, .ce, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata,
      .cpu_rdata, .cpu_rvalid, .int_stat_rdata(8'h5c), .irq_event, .fifo_levels(4'ha),
      .rx_head, .rx_fifo_pop, .tx_fifo_push, .tx_fifo_entry, .addr_cfg, .rx_addr_stb,
      .rx_addr1, .rx_addr2, .rx_addr_ok, .rx_addr_drop, .rx_bit_stb, .rx_bit,
      .rx_pkt_busy, .rx_clk_en, .rx_hunt, .tx_fifo_empty, .tx_pkt_busy, .tx_byte_done,
      .tx_byte_last, .tx_byte_abort, .tx_clk_en, .tx_send_data, .tx_fill_idle,
      .tx_fill_flags, .tx_fcs_req, .tx_abort_req);

   hcs_far_model far_u (.ref_clk, .resetn, .tx_fifo_push, .tx_fifo_entry, .line_go,
      .line_cnt, .line_val, .tx_byte_done, .tx_byte_last, .tx_byte_abort, .rx_bit_stb,
      .rx_bit);

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic results;
      if (err_total == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", nm, exp, got);
         err_total++;
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cpu_req   <= 1'b1;
      cpu_we    <= 1'b1;
      cpu_addr  <= a;
      cpu_wdata <= d;
      @(posedge ref_clk);
      cpu_req <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a);
      @(posedge ref_clk);
      cpu_req  <= 1'b1;
      cpu_we   <= 1'b0;
      cpu_addr <= a;
      #1;
      if (a == ADDR_FIFO) chk("rx_fifo_pop", 10'h1, 10'(rx_fifo_pop));
      @(posedge ref_clk);
      cpu_req <= 1'b0;
      #1;
      chk("cpu_rvalid", 10'h1, 10'(cpu_rvalid));
      rd_v = cpu_rdata;
   endtask

   task automatic t_regs;
      rd(ADDR_CTRL1);
      chk("ctrl1_reset", 10'(CTRL1_RESET), 10'(rd_v));
      rd(ADDR_STATUS);
      chk("intgen_reset", 10'h0, 10'(rd_v[STAT_INTGEN]));
      wr(ADDR_CTRL1, 8'h84);
      rd(ADDR_CTRL1);
      chk("ctrl1_rdback", 10'h84, 10'(rd_v));
      rd(5'h1f);
      chk("unmapped", 10'(RDATA_NONE), 10'(rd_v));
      wr(ADDR_CTRL1, 8'h00);
   endtask

   task automatic tag_byte(input logic [7:0] c, input logic [7:0] d, input logic fcs);
      wr(ADDR_CTRL1, c);
      wr(ADDR_FIFO, d);
      #1;
      chk("tx_fifo_push", 10'h1, 10'(tx_fifo_push));
      chk("tx_fifo_entry", {c[4], c[3], d}, tx_fifo_entry);
      rd(ADDR_CTRL1);
      chk("ctrl1_tags", 10'h0, 10'(rd_v[4:3]));
      for (int n = 0; n < 20 && tx_byte_done !== 1'b1; n++) step(1);
      step(1);
      chk("tx_fcs_req", 10'(fcs), 10'(tx_fcs_req));
      chk("tx_abort_req", 10'(!fcs), 10'(tx_abort_req));
   endtask

   task automatic t_tx;
      wr(ADDR_CTRL1, 8'h20);
      step(1);
      chk("tx_clk_en", 10'h1, 10'(tx_clk_en));
      chk("tx_fill_idle", 10'h1, 10'(tx_fill_idle));
      chk("tx_fill_flags", 10'h0, 10'(tx_fill_flags));
      wr(ADDR_CTRL1, 8'h24);
      step(1);
      chk("tx_fill_flags", 10'h1, 10'(tx_fill_flags));
      chk("tx_fill_idle", 10'h0, 10'(tx_fill_idle));
      @(posedge ref_clk);
      tx_fifo_empty <= 1'b0;
      tx_pkt_busy   <= 1'b1;
      wr(ADDR_CTRL1, 8'h00);
      step(2);
      chk("tx_send_data", 10'h1, 10'(tx_send_data));
      chk("tx_clk_en_busy", 10'h1, 10'(tx_clk_en));
      @(posedge ref_clk);
      tx_fifo_empty <= 1'b1;
      tx_pkt_busy   <= 1'b0;
      step(2);
      chk("tx_clk_en_off", 10'h0, 10'(tx_clk_en));
      chk("tx_send_off", 10'h0, 10'(tx_send_data));
   endtask

   task automatic t_rx;
      chk("rx_clk_en_rst", 10'h0, 10'(rx_clk_en));
      wr(ADDR_CTRL1, 8'h40);
      step(1);
      chk("rx_hunt", 10'h1, 10'(rx_hunt));
      chk("rx_clk_en", 10'h1, 10'(rx_clk_en));
      @(posedge ref_clk);
      rx_pkt_busy <= 1'b1;
      wr(ADDR_CTRL1, 8'h00);
      step(2);
      chk("rx_clk_en_busy", 10'h1, 10'(rx_clk_en));
      @(posedge ref_clk);
      rx_pkt_busy <= 1'b0;
      step(2);
      chk("rx_clk_en_off", 10'h0, 10'(rx_clk_en));
      chk("rx_hunt_off", 10'h0, 10'(rx_hunt));
   endtask

   task automatic t_irq;
      @(posedge ref_clk);
      irq_event <= 1'b1;
      @(posedge ref_clk);
      irq_event <= 1'b0;
      rd(ADDR_STATUS);
      chk("intgen_set", 10'h1, 10'(rd_v[STAT_INTGEN]));
      rd(ADDR_INT_STAT);
      chk("int_stat", 10'h5c, 10'(rd_v));
      rd(ADDR_STATUS);
      chk("intgen_clr", 10'h0, 10'(rd_v[STAT_INTGEN]));
      @(posedge ref_clk);
      irq_event <= 1'b1;
      rd(ADDR_INT_STAT);
      irq_event <= 1'b0;
      rd(ADDR_STATUS);
      chk("intgen_set_wins", 10'h1, 10'(rd_v[STAT_INTGEN]));
   endtask

   task automatic send_idle(input logic [4:0] n, input logic v, input logic exp);
      @(posedge ref_clk);
      line_go  <= 1'b1;
      line_cnt <= n;
      line_val <= v;
      @(posedge ref_clk);
      line_go <= 1'b0;
      step(int'(n) + 3);
      rd(ADDR_STATUS);
      chk("idle_chan", 10'(exp), 10'(rd_v[STAT_IDLE]));
   endtask

   task automatic t_bstat;
      for (int i = 0; i < 4; i++) begin
         rx_head <= '{status: 2'(i), data: 8'h30 + 8'(i)};
         rd(ADDR_STATUS);
         chk("byte_status", 10'(i), 10'(rd_v[5:4]));
         chk("fifo_levels", 10'ha, 10'(rd_v[3:0]));
         rd(ADDR_FIFO);
         chk("rx_fifo_data", 10'(8'h30 + 8'(i)), 10'(rd_v));
      end
   endtask

   task automatic addr_try(input logic [7:0] a1, input logic [7:0] a2, input logic ok);
      @(posedge ref_clk);
      rx_addr_stb <= 1'b1;
      rx_addr1    <= a1;
      rx_addr2    <= a2;
      @(posedge ref_clk);
      rx_addr_stb <= 1'b0;
      #1;
      chk("rx_addr_ok", 10'(ok), 10'(rx_addr_ok));
      chk("rx_addr_drop", 10'(!ok), 10'(rx_addr_drop));
   endtask

   task automatic t_addr;
      addr_cfg <= '{mask1: 6'h15, bit10: 1'b0, en1: 1'b1, mask2: 7'h0, en2: 1'b0, seven: 1'b0};
      addr_try(8'h03, 8'h00, 1'b1);
      wr(ADDR_CTRL1, 8'h80);
      addr_try(8'h03, 8'h00, 1'b0);
      addr_try(8'h55, 8'h00, 1'b1);
      addr_try(8'hff, 8'h00, 1'b1);
      addr_cfg <= '{mask1: 6'h15, bit10: 1'b0, en1: 1'b1, mask2: 7'h2a, en2: 1'b1, seven: 1'b0};
      addr_try(8'h54, 8'h54, 1'b1);
      addr_try(8'h54, 8'h56, 1'b0);
      addr_try(8'hfc, 8'hfe, 1'b1);
      wr(ADDR_CTRL1, 8'h00);
   endtask

   task automatic t_ce;
      @(posedge ref_clk);
      ce <= 1'b0;
      wr(ADDR_CTRL1, 8'h40);
      step(2);
      chk("rx_hunt_frozen", 10'h0, 10'(rx_hunt));
      @(posedge ref_clk);
      ce <= 1'b1;
      rd(ADDR_CTRL1);
      chk("ctrl1_frozen", 10'h0, 10'(rd_v));
   endtask

   initial begin
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs;
      tag_byte(8'h10, 8'h5a, 1'b1);
      tag_byte(8'h08, 8'ha5, 1'b0);
      t_tx;
      t_rx;
      t_irq;
      send_idle(5'd14, 1'b1, 1'b0);
      send_idle(5'd1, 1'b1, 1'b1);
      send_idle(5'd1, 1'b0, 1'b0);
      t_bstat;
      t_addr;
      t_ce;
      results;
   end

   // The whole sequence needs well under a thousand cycles.
   initial begin
      #50000;
      err_total++;
      results;
   end
endmodule // hcs_slice_tb
